// ===== ppio_defines.svh
// register offsets, reset values and timing counts of the port pin i/o control block
`ifndef PPIO_DEFINES_SVH
`define PPIO_DEFINES_SVH

// port and bus widths
`define PPIO_W              8
`define PPIO_AW             8

// register offsets, one byte each
`define PPIO_OFF_DATA       8'h00
`define PPIO_OFF_INPUT      8'h01
`define PPIO_OFF_DIR        8'h02
`define PPIO_OFF_RDRV       8'h03
`define PPIO_OFF_PULL_EN    8'h04
`define PPIO_OFF_POLARITY   8'h05
`define PPIO_OFF_OPEN_DRAIN 8'h06
`define PPIO_OFF_AD_DATA    8'h07
`define PPIO_OFF_AD_DIR     8'h08
`define PPIO_OFF_AD_RDRV    8'h09
`define PPIO_OFF_AD_PULL_HI 8'h0a
`define PPIO_OFF_LAST       8'h0a

// reset and reserved values
`define PPIO_RST_BYTE       8'h00
`define PPIO_RSVD_VALUE     8'h00
`define PPIO_GPIO_MASK_DEF  8'hff

// bus clock cycles software waits after a direction change
`define PPIO_DIR_SETTLE_CYC 2

`endif

// ===== ppio_pad_ctl.sv
// pad drive, pull and drive strength selection for one port
`timescale 1ns/1ns
`include "ppio_defines.svh"
module ppio_pad_ctl #(
  parameter logic [`PPIO_W-1:0] GPIO_MASK = `PPIO_GPIO_MASK_DEF, // pins able to do gpio
  parameter bit                 HAS_PPS   = 1'b1,                // polarity select present
  parameter bit                 HAS_WOM   = 1'b1                 // open-drain mode present
) (
  ppio_pad_if.pad p
);
  logic [`PPIO_W-1:0] own_oe;  // output enable from owner
  logic [`PPIO_W-1:0] own_out; // output level from owner
  logic [`PPIO_W-1:0] wom_eff; // open-drain bits that exist
  logic [`PPIO_W-1:0] pps_eff; // polarity bits that exist

  // peripheral wins; direction ignored while it owns the pin
  assign own_oe  = (p.periph_en & p.periph_oe) | (~p.periph_en & p.dir & GPIO_MASK);
  assign own_out = (p.periph_en & p.periph_out) | (~p.periph_en & p.data);
  assign wom_eff = HAS_WOM ? p.wom : '0;
  assign pps_eff = HAS_PPS ? p.pps : '0;

  // open-drain: a high level is released, not driven
  assign p.pin_o  = own_out;
  assign p.pin_oe = own_oe & ~(wom_eff & own_out);
  // pull only for inputs or open-drain outputs, never push-pull
  assign p.pull_en = p.pe & (~own_oe | wom_eff);
  // polarity only counts on inputs; open-drain gets a pull-up
  assign p.pull_up = ~(pps_eff & ~own_oe);
  // drive strength follows the owner's output enable, by gpio or peripheral, so an open-drain pin released high keeps it
  assign p.rdrv    = p.rdr & own_oe;
endmodule

// ===== ppio_pad_if.sv
// configuration and pad signals between register file and pad control
`timescale 1ns/1ns
`include "ppio_defines.svh"
interface ppio_pad_if;
  logic [`PPIO_W-1:0] dir;        // direction bits
  logic [`PPIO_W-1:0] data;       // data register bits
  logic [`PPIO_W-1:0] rdr;        // reduced drive bits
  logic [`PPIO_W-1:0] pe;         // pull enable bits
  logic [`PPIO_W-1:0] pps;        // polarity bits
  logic [`PPIO_W-1:0] wom;        // open-drain bits
  logic [`PPIO_W-1:0] periph_en;  // peripheral owns pin
  logic [`PPIO_W-1:0] periph_out; // peripheral output level
  logic [`PPIO_W-1:0] periph_oe;  // peripheral output enable
  logic [`PPIO_W-1:0] pin_o;      // pad output level
  logic [`PPIO_W-1:0] pin_oe;     // pad output enable
  logic [`PPIO_W-1:0] pull_en;    // pull device on
  logic [`PPIO_W-1:0] pull_up;    // 1 = pull-up, 0 = pull-down
  logic [`PPIO_W-1:0] rdrv;       // reduced drive to pad

  modport ctrl (output dir, data, rdr, pe, pps, wom, periph_en, periph_out, periph_oe,
                input  pin_o, pin_oe, pull_en, pull_up, rdrv);
  modport pad  (input  dir, data, rdr, pe, pps, wom, periph_en, periph_out, periph_oe,
                output pin_o, pin_oe, pull_en, pull_up, rdrv);
endinterface

// ===== ppio_pin_model.sv
// outside world of one port: pin wires, outside drivers and pulls
`timescale 1ns/1ns
module ppio_pin_model (
  input  wire logic               clk_i,
  input  wire ppio_pkg::ppio_byte_t out_i,
  input  wire ppio_pkg::ppio_byte_t oe_i,
  input  wire ppio_pkg::ppio_byte_t pull_en_i,
  input  wire ppio_pkg::ppio_byte_t pull_up_i,
  input  wire ppio_pkg::ppio_byte_t ext_en_i,
  input  wire ppio_pkg::ppio_byte_t ext_val_i,
  output ppio_pkg::ppio_byte_t      lvl_o
);
  // undriven, unpulled bits flip every cycle so no read can rely on them
  ppio_pkg::ppio_byte_t float_q = 8'h00;

  // free-running toggle for floating wires
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // chip driver wins, then outside driver, then pull, else floating
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
               | (~oe_i & ~ext_en_i & pull_en_i & pull_up_i)
               | (~oe_i & ~ext_en_i & ~pull_en_i & float_q);
endmodule

// ===== ppio_pkg.sv
// types shared by the port pin i/o control block
`include "ppio_defines.svh"
package ppio_pkg;

  typedef logic [`PPIO_W-1:0] ppio_byte_t;

  // every register of the top module
  typedef struct packed {
    ppio_byte_t data;      // port data register
    ppio_byte_t dir;       // direction, 1 = output
    ppio_byte_t rdr;       // reduced drive
    ppio_byte_t pe;        // pull enable
    ppio_byte_t pps;       // pull polarity, 1 = pull-down
    ppio_byte_t wom;       // open-drain (wired-or) mode
    ppio_byte_t ad_data;   // analog port upper half data
    ppio_byte_t ad_dir;    // analog port upper half direction
    ppio_byte_t ad_rdr;    // analog port upper half reduced drive
    ppio_byte_t ad_pe;     // analog port upper half pull enable
    ppio_byte_t rdata;     // read data, valid one cycle
  } ppio_regs_t;

  // synchroniser state
  typedef struct packed {
    ppio_byte_t s1;        // first stage, read only by s2
    ppio_byte_t s2;
    ppio_byte_t s3;
    ppio_byte_t lvl;       // accepted pin level
  } ppio_sync_t;

endpackage

// ===== ppio_sync.sv
// three-flop pin input synchroniser with agreement filter
`timescale 1ns/1ns
`include "ppio_defines.svh"
module ppio_sync (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [`PPIO_W-1:0]  pin_i,
  output logic      [`PPIO_W-1:0]  lvl_o
);
  ppio_pkg::ppio_sync_t q;  // registered state
  ppio_pkg::ppio_sync_t d;  // next state

  // shift chain; a change counts once stages two and three agree
  always_comb begin
    d     = q;
    d.s1  = pin_i;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
  end

  // synchronous reset to all low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lvl_o = q.lvl;
endmodule

// ===== ppio_top.sv
// port pin i/o control: registers, read mux, pad control and pin synchronisers
`timescale 1ns/1ns
`include "ppio_defines.svh"
module ppio_top #(
  parameter logic [`PPIO_W-1:0] GPIO_MASK  = `PPIO_GPIO_MASK_DEF, // 0 for irq or debug pins
  parameter bit                 HAS_INPUT  = 1'b1,                // input register present
  parameter bit                 HAS_RDR_PE = 1'b1,                // drive and pull present
  parameter bit                 HAS_PPS    = 1'b1,                // polarity present
  parameter bit                 HAS_WOM    = 1'b1                 // open-drain present
) (
  input  wire logic                SYS_CLK_I,
  input  wire logic                RESET_I,
  input  wire logic [`PPIO_AW-1:0] ADDR_I,
  input  wire logic [`PPIO_W-1:0]  WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [`PPIO_W-1:0]  RDATA_O,
  input  wire logic [`PPIO_W-1:0]  PIN_I,
  output logic      [`PPIO_W-1:0]  PIN_O,
  output logic      [`PPIO_W-1:0]  PIN_OE_O,
  output logic      [`PPIO_W-1:0]  PULL_EN_O,
  output logic      [`PPIO_W-1:0]  PULL_UP_O,
  output logic      [`PPIO_W-1:0]  RDRV_O,
  input  wire logic [`PPIO_W-1:0]  PERIPH_EN_I,
  input  wire logic [`PPIO_W-1:0]  PERIPH_OUT_I,
  input  wire logic [`PPIO_W-1:0]  PERIPH_OE_I,
  input  wire logic [`PPIO_W-1:0]  AD_PIN_I,
  output logic      [`PPIO_W-1:0]  AD_PIN_O,
  output logic      [`PPIO_W-1:0]  AD_PIN_OE_O,
  output logic      [`PPIO_W-1:0]  AD_PULL_EN_O,
  output logic      [`PPIO_W-1:0]  AD_PULL_UP_O,
  output logic      [`PPIO_W-1:0]  AD_RDRV_O
);

  ppio_pkg::ppio_regs_t q;         // registered state
  ppio_pkg::ppio_regs_t d;         // next state
  logic [`PPIO_W-1:0]   pin_lvl;   // synchronised main port pins
  logic [`PPIO_W-1:0]   ad_lvl;    // synchronised analog port pins

  ppio_pad_if pad_m ();            // main port pad bundle
  ppio_pad_if pad_a ();            // analog port pad bundle

  // data address view: register bit when output, pin when input
  function automatic logic [`PPIO_W-1:0] data_view(input logic [`PPIO_W-1:0] dir,
                                                   input logic [`PPIO_W-1:0] dat,
                                                   input logic [`PPIO_W-1:0] lvl);
    data_view = (dir & dat) | (~dir & lvl);
  endfunction

  // pin inputs pass the synchroniser before any read
  ppio_sync u_sync_m (
    .clk_i (SYS_CLK_I),
    .rst_i (RESET_I),
    .pin_i (PIN_I),
    .lvl_o (pin_lvl)
  );

  ppio_sync u_sync_a (
    .clk_i (SYS_CLK_I),
    .rst_i (RESET_I),
    .pin_i (AD_PIN_I),
    .lvl_o (ad_lvl)
  );

  // register writes and read mux
  always_comb begin
    d       = q;
    d.rdata = `PPIO_RSVD_VALUE; // read data lasts a single cycle
    // writes land whatever the pin usage; effect decided in the pad
    if (WR_I) begin
      case (ADDR_I)
        `PPIO_OFF_DATA: begin
          d.data = WDATA_I;
        end
        `PPIO_OFF_DIR: begin
          d.dir = WDATA_I;
        end
        `PPIO_OFF_RDRV: begin
          if (HAS_RDR_PE) d.rdr = WDATA_I;
        end
        `PPIO_OFF_PULL_EN: begin
          if (HAS_RDR_PE) d.pe = WDATA_I;
        end
        `PPIO_OFF_POLARITY: begin
          if (HAS_PPS) d.pps = WDATA_I;
        end
        `PPIO_OFF_OPEN_DRAIN: begin
          if (HAS_WOM) d.wom = WDATA_I;
        end
        `PPIO_OFF_AD_DATA: begin
          d.ad_data = WDATA_I;
        end
        `PPIO_OFF_AD_DIR: begin
          d.ad_dir = WDATA_I;
        end
        `PPIO_OFF_AD_RDRV: begin
          d.ad_rdr = WDATA_I;
        end
        `PPIO_OFF_AD_PULL_HI: begin
          d.ad_pe = WDATA_I;
        end
        // reserved and input register: write dropped
        default: begin
          d.rdata = `PPIO_RSVD_VALUE;
        end
      endcase
    end
    // strobes never coincide, so read mux may overwrite rdata freely
    if (RD_I) begin
      case (ADDR_I)
        `PPIO_OFF_DATA: begin
          d.rdata = data_view(q.dir, q.data, pin_lvl);
        end
        `PPIO_OFF_INPUT: begin
          d.rdata = HAS_INPUT ? pin_lvl : `PPIO_RSVD_VALUE;
        end
        `PPIO_OFF_DIR: begin
          d.rdata = q.dir;
        end
        `PPIO_OFF_RDRV: begin
          d.rdata = q.rdr;
        end
        `PPIO_OFF_PULL_EN: begin
          d.rdata = q.pe;
        end
        `PPIO_OFF_POLARITY: begin
          d.rdata = q.pps;
        end
        `PPIO_OFF_OPEN_DRAIN: begin
          d.rdata = q.wom;
        end
        `PPIO_OFF_AD_DATA: begin
          d.rdata = data_view(q.ad_dir, q.ad_data, ad_lvl);
        end
        `PPIO_OFF_AD_DIR: begin
          d.rdata = q.ad_dir;
        end
        `PPIO_OFF_AD_RDRV: begin
          d.rdata = q.ad_rdr;
        end
        `PPIO_OFF_AD_PULL_HI: begin
          d.rdata = q.ad_pe;
        end
        // anything unmapped reads as zero
        default: begin
          d.rdata = `PPIO_RSVD_VALUE;
        end
      endcase
    end
  end

  // all state on one synchronous reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // main port pad bundle, one bit per pin
  assign pad_m.dir        = q.dir;
  assign pad_m.data       = q.data;
  assign pad_m.rdr        = q.rdr;
  assign pad_m.pe         = q.pe;
  assign pad_m.pps        = q.pps;
  assign pad_m.wom        = q.wom;
  assign pad_m.periph_en  = PERIPH_EN_I;
  assign pad_m.periph_out = PERIPH_OUT_I;
  assign pad_m.periph_oe  = PERIPH_OE_I;

  // analog half: the converter only samples, never drives
  assign pad_a.dir        = q.ad_dir;
  assign pad_a.data       = q.ad_data;
  assign pad_a.rdr        = q.ad_rdr;
  assign pad_a.pe         = q.ad_pe;
  assign pad_a.pps        = '0;
  assign pad_a.wom        = '0;
  assign pad_a.periph_en  = '0;
  assign pad_a.periph_out = '0;
  assign pad_a.periph_oe  = '0;

  ppio_pad_ctl #(
    .GPIO_MASK (GPIO_MASK),
    .HAS_PPS   (HAS_PPS),
    .HAS_WOM   (HAS_WOM)
  ) u_pad_m (
    .p (pad_m.pad)
  );

  // no polarity or open-drain on the analog half: pull is always up
  ppio_pad_ctl #(
    .GPIO_MASK (`PPIO_GPIO_MASK_DEF),
    .HAS_PPS   (1'b0),
    .HAS_WOM   (1'b0)
  ) u_pad_a (
    .p (pad_a.pad)
  );

  // outputs
  assign RDATA_O      = q.rdata;
  assign PIN_O        = pad_m.pin_o;
  assign PIN_OE_O     = pad_m.pin_oe;
  assign PULL_EN_O    = pad_m.pull_en;
  assign PULL_UP_O    = pad_m.pull_up;
  assign RDRV_O       = pad_m.rdrv;
  assign AD_PIN_O     = pad_a.pin_o;
  assign AD_PIN_OE_O  = pad_a.pin_oe;
  assign AD_PULL_EN_O = pad_a.pull_en;
  assign AD_PULL_UP_O = pad_a.pull_up;
  assign AD_RDRV_O    = pad_a.rdrv;

  // checks on the block's own behaviour
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);

  AST_AD_PULL_INPUT_ONLY: assert property ((q.ad_dir & AD_PULL_EN_O) == '0)
    else $error("analog pull active on an output pin");
  AST_RSVD_READ_ZERO: assert property (RD_I && ADDR_I > `PPIO_OFF_LAST |=> RDATA_O == `PPIO_RSVD_VALUE)
    else $error("reserved location read not zero");
  AST_NON_GPIO_PIN: assert property ((~GPIO_MASK & ~PERIPH_EN_I & PIN_OE_O) == '0)
    else $error("non-gpio pin driven by gpio");
  AST_DIR_WRITE_TAKEN: assert property (WR_I && ADDR_I == `PPIO_OFF_DIR |=> q.dir == $past(WDATA_I))
    else $error("direction write lost");
  AST_NO_PULL_PUSHPULL: assert property ((PULL_EN_O & PIN_OE_O & ~q.wom) == '0)
    else $error("pull on push-pull output");
  AST_GPIO_OUT_LEVEL: assert property (((~PERIPH_EN_I & q.dir & GPIO_MASK) & (PIN_O ^ q.data)) == '0)
    else $error("gpio output not data register");
  AST_DATA_READ_SRC: assert property (RD_I && ADDR_I == `PPIO_OFF_DATA
                                      |=> RDATA_O == $past((q.dir & q.data) | (~q.dir & pin_lvl)))
    else $error("data read source wrong");
  AST_INPUT_READ: assert property (RD_I && ADDR_I == `PPIO_OFF_INPUT && HAS_INPUT
                                   |=> RDATA_O == $past(pin_lvl))
    else $error("input read not pin level");
  AST_PERIPH_OWNS: assert property ((PERIPH_EN_I & ~q.wom & (PIN_OE_O ^ PERIPH_OE_I)) == '0)
    else $error("direction used while peripheral owns pin");
  AST_RDRV_IDLE: assert property ((RDRV_O & ~(PIN_OE_O | q.wom)) == '0)
    else $error("reduced drive on undriven pin");
  AST_PIN_SYNC: assert property ((PIN_I == $past(PIN_I)) [*6] |=> pin_lvl == $past(PIN_I))
    else $error("synchronised level does not follow stable pin");

  // main port: pins that no peripheral owns and gpio does not drive take the pull setting as written
  AST_PULL_FOLLOWS_ENABLE: assert property (
    ((PULL_EN_O ^ q.pe) & ~PERIPH_EN_I & ~(q.dir & GPIO_MASK)) == '0)
    else $error("pull enable not applied on input pin");
  // input pins: polarity bit picks up or down
  AST_POLARITY_ON_INPUT: assert property (
    ((PULL_UP_O ^ ~q.pps) & ~PERIPH_EN_I & ~(q.dir & GPIO_MASK)) == '0)
    else $error("pull direction not from polarity bit");
  // open-drain pins never drive a high level
  AST_OPEN_DRAIN_NO_HIGH: assert property ((PIN_OE_O & PIN_O & q.wom) == '0)
    else $error("open-drain pin drives high");
  // gpio-owned pins: enable follows direction, released high on open-drain
  AST_DIR_DRIVES_OE: assert property (((PIN_OE_O ^ (q.dir & GPIO_MASK & ~(q.wom & q.data))) & ~PERIPH_EN_I) == '0)
    else $error("gpio output enable not from direction");
  // writes to the input register or unmapped places leave all settings alone
  AST_RSVD_WRITE_IGNORED: assert property (
    WR_I && (ADDR_I == `PPIO_OFF_INPUT || ADDR_I > `PPIO_OFF_LAST)
    |=> {q.data, q.dir, q.rdr, q.pe, q.pps, q.wom} == $past({q.data, q.dir, q.rdr, q.pe, q.pps, q.wom})
        && {q.ad_data, q.ad_dir, q.ad_rdr, q.ad_pe} == $past({q.ad_data, q.ad_dir, q.ad_rdr, q.ad_pe}))
    else $error("ignored write changed a setting");
  // driven pins carry the reduced drive bit as written
  AST_RDRV_DRIVEN: assert property (((RDRV_O ^ q.rdr) & PIN_OE_O) == '0)
    else $error("reduced drive lost on driven pin");

  // analog half: no peripheral, so direction alone decides
  // input pins take the pull enable bit
  AST_AD_PULL_FOLLOWS: assert property (((AD_PULL_EN_O ^ q.ad_pe) & ~q.ad_dir) == '0)
    else $error("analog pull enable not applied on input pin");
  // reduced drive only where driven
  AST_AD_RDRV_DRIVEN: assert property ((AD_RDRV_O ^ (q.ad_rdr & q.ad_dir)) == '0)
    else $error("analog reduced drive wrong");
  // driven pins show the data register
  AST_AD_OUT_LEVEL: assert property (((AD_PIN_O ^ q.ad_data) & AD_PIN_OE_O) == '0)
    else $error("analog output not data register");

  // main scenarios the bench is expected to reach
  COV_READ_OUTPUT_DATA: cover property (RD_I && ADDR_I == `PPIO_OFF_DATA && q.dir != '0);
  COV_PULL_DOWN_INPUT: cover property (|(PULL_EN_O & ~PULL_UP_O));
  COV_PERIPH_DRIVES: cover property (|(PERIPH_EN_I & PIN_OE_O));
  COV_OPEN_DRAIN_PULL: cover property (|(q.wom & q.dir & PULL_EN_O));
  COV_AD_PULL_ACTIVE: cover property (|AD_PULL_EN_O);
endmodule

// ===== ppio_top_tb.sv
// self-checking bench for the port pin i/o control block
`timescale 1ns/1ns
`include "ppio_defines.svh"
module ppio_top_tb;
  typedef ppio_pkg::ppio_byte_t ppio_b_t;
  logic    clk;        // bus clock
  logic    rst;        // synchronous reset
  logic    wr_s;       // write strobe
  logic    rd_s;       // read strobe
  ppio_b_t addr;       // register address
  ppio_b_t wdata;      // write data
  ppio_b_t rdata;      // read data
  ppio_b_t pin_i;      // resolved main pins
  ppio_b_t pin_o;      // pad levels
  ppio_b_t pin_oe;     // pad enables
  ppio_b_t pull_en;    // pulls on
  ppio_b_t pull_up;    // pull direction
  ppio_b_t rdrv;       // reduced drive
  ppio_b_t p_en;       // peripheral owns pin
  ppio_b_t p_out;      // peripheral level
  ppio_b_t p_oe;       // peripheral enable
  ppio_b_t ad_pin_i;   // resolved analog pins
  ppio_b_t ad_o;       // analog pad levels
  ppio_b_t ad_oe;      // analog pad enables
  ppio_b_t ad_pe;      // analog pulls on
  ppio_b_t ad_pu;      // analog pull direction
  ppio_b_t ad_rdrv;    // analog reduced drive
  ppio_b_t ext_en;     // outside drivers, main port
  ppio_b_t ext_val;
  ppio_b_t ad_ext_en;  // outside drivers, analog half
  ppio_b_t ad_ext_val;
  int      mismatches;
  int      checked;

  // bit 7 masked off: stands in for an irq or debug pin
  ppio_top #(.GPIO_MASK(8'h7f)) dut (.SYS_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .PIN_I(pin_i),
    .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PULL_EN_O(pull_en), .PULL_UP_O(pull_up),
    .RDRV_O(rdrv), .PERIPH_EN_I(p_en), .PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe),
    .AD_PIN_I(ad_pin_i), .AD_PIN_O(ad_o), .AD_PIN_OE_O(ad_oe), .AD_PULL_EN_O(ad_pe),
    .AD_PULL_UP_O(ad_pu), .AD_RDRV_O(ad_rdrv));
  ppio_pin_model pm (.clk_i(clk), .out_i(pin_o), .oe_i(pin_oe), .pull_en_i(pull_en),
    .pull_up_i(pull_up), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin_i));
  ppio_pin_model am (.clk_i(clk), .out_i(ad_o), .oe_i(ad_oe), .pull_en_i(ad_pe),
    .pull_up_i(ad_pu), .ext_en_i(ad_ext_en), .ext_val_i(ad_ext_val), .lvl_o(ad_pin_i));

  // 100 MHz clock
  always #5 clk = ~clk;

  // compare and count
  task automatic chk(input string nm, input ppio_b_t seen, input ppio_b_t exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle write; returns once the edge's updates have landed
  task automatic wr(input ppio_b_t a, input ppio_b_t d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask

  // one-cycle read, data taken in the cycle after the strobe only
  task automatic rdc(input string nm, input ppio_b_t a, input ppio_b_t exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask

  // software wait after a direction or pin change, with margin for the filter
  task automatic settle();
    repeat (`PPIO_DIR_SETTLE_CYC + 4) @(posedge clk);
    #1;
  endtask

  // reset values over the whole map, reserved places
  task automatic t_reset_map();
    ppio_b_t e;
    // synchroniser leaves reset at zero: let pin levels reach it first
    settle();
    for (int a = 0; a < 12; a++) begin
      e = (a < 2) ? 8'h3c : (a == 7) ? 8'h96 : 8'h00;
      rdc("reset map", ppio_b_t'(a), e);
    end
    wr(8'hff, 8'hff);
    wr(8'h0b, 8'h5a);
    rdc("rsvd ff", 8'hff, 8'h00);
    rdc("rsvd 0b", 8'h0b, 8'h00);
    chk("reset oe", pin_oe, 8'h00);
    chk("reset pull", pull_en, 8'h00);
  endtask

  // data, direction, input register and synchroniser
  task automatic t_data_dir();
    @(posedge clk);
    ext_en <= 8'hf0;
    ext_val <= 8'h43;
    wr(8'h00, 8'ha5);
    wr(8'h02, 8'h8f);
    settle();
    chk("gpio oe", pin_oe, 8'h0f);
    chk("gpio out", pin_o & pin_oe, 8'h05);
    rdc("data rd", 8'h00, 8'hc5);
    rdc("input rd", 8'h01, 8'h45);
    wr(8'h01, 8'hff);
    rdc("input ro", 8'h01, 8'h45);
    @(posedge clk);
    ext_val <= 8'h33;
    rdc("sync early", 8'h01, 8'h45);
    settle();
    rdc("sync late", 8'h01, 8'h35);
  endtask

  // pull enable, polarity and open-drain mode
  task automatic t_pull();
    wr(8'h04, 8'hff);
    wr(8'h05, 8'h0f);
    chk("pull en", pull_en, 8'hf0);
    chk("pull up", pull_up & pull_en, 8'hf0);
    wr(8'h05, 8'hf0);
    chk("pull dn", pull_up & pull_en, 8'h00);
    wr(8'h06, 8'h03);
    wr(8'h05, 8'hff);
    chk("od oe", pin_oe, 8'h0e);
    chk("od pull", pull_en, 8'hf3);
    chk("od up", pull_up & 8'h03, 8'h03);
    rdc("pe rd", 8'h04, 8'hff);
  endtask

  // peripheral takes pins, direction still picks read source
  task automatic t_periph();
    wr(8'h06, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h0f);
    wr(8'h03, 8'hff);
    wr(8'h05, 8'h00);
    @(posedge clk);
    p_en <= 8'h81;
    p_oe <= 8'h80;
    p_out <= 8'h80;
    ext_en <= 8'h70;
    ext_val <= 8'h70;
    settle();
    chk("per oe", pin_oe, 8'h8e);
    chk("per out", pin_o & pin_oe, 8'h80);
    chk("per rdrv", rdrv, 8'h8e);
    rdc("per data", 8'h00, 8'hf0);
    rdc("per input", 8'h01, 8'hf1);
    @(posedge clk);
    p_en <= 8'h00;
  endtask

  // analog half: pull enable acts on inputs only
  task automatic t_analog();
    wr(8'h0a, 8'hff);
    wr(8'h08, 8'h0f);
    wr(8'h07, 8'h5a);
    wr(8'h09, 8'hff);
    settle();
    chk("ad oe", ad_oe, 8'h0f);
    chk("ad pull", ad_pe, 8'hf0);
    chk("ad up", ad_pu, 8'hff);
    chk("ad rdrv", ad_rdrv, 8'h0f);
    chk("ad out", ad_o & ad_oe, 8'h0a);
    rdc("ad data", 8'h07, 8'h9a);
  endtask

  // counts and verdict, the only place the run ends
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard: a run that outlives this counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    p_en = 8'h00;
    p_out = 8'h00;
    p_oe = 8'h00;
    ext_en = 8'hff;
    ext_val = 8'h3c;
    ad_ext_en = 8'hff;
    ad_ext_val = 8'h96;
    mismatches = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_map();
    t_data_dir();
    t_pull();
    t_periph();
    t_analog();
    print_verdict();
  end
endmodule
